/* File: include/aacr_defines.svh */
/*
 * Holds the named constants of the analog auxiliary control registers:
 * byte addresses, field positions, reset values and the unlock keys.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef AACR_DEFINES_SVH
`define AACR_DEFINES_SVH

// ------------
// Register byte addresses
// ------------
`define AACR_ADDR_SUPPLY_MONITOR_CONTROL 32'hffff_0440
`define AACR_ADDR_COMPARATOR_CONTROL 32'hffff_0444
`define AACR_ADDR_EVENT_STATUS 32'hffff_0460
`define AACR_ADDR_EVENT_MASK 32'hffff_0464
`define AACR_ADDR_BUFFER_CONFIG_KEY_FIRST 32'hffff_0650
`define AACR_ADDR_OPAMP_BUFFER_CONFIG 32'hffff_0654
`define AACR_ADDR_BUFFER_CONFIG_KEY_SECOND 32'hffff_0658

// ------------
// Unlock keys
// ------------
`define AACR_KEY_FIRST 16'h009a
`define AACR_KEY_SECOND 16'h000c

// ------------
// Supply monitor control fields
// ------------
`define AACR_SUP_ABOVE_BIT 3
`define AACR_SUP_TRIP_BIT 2
`define AACR_SUP_ENABLE_BIT 1
`define AACR_SUP_FLAG_BIT 0

// ------------
// Comparator control fields
// ------------
`define AACR_CMP_ENABLE_BIT 10
`define AACR_CMP_NEG_HI 9
`define AACR_CMP_NEG_LO 8
`define AACR_CMP_ROUTE_HI 7
`define AACR_CMP_ROUTE_LO 6
`define AACR_CMP_RISE_BIT 1
`define AACR_CMP_FALL_BIT 0
`define AACR_ROUTE_PIN 2'h2
`define AACR_ROUTE_IRQ 2'h3

// ------------
// Widths and reset values
// ------------
`define AACR_OPAMP_CHANNELS 4
`define AACR_EVENT_COUNT 3
`define AACR_RESET_ZERO 32'h0000_0000
`define AACR_RESET_BIT 1'h0
`define AACR_RESET_BIT_HIGH 1'h1

`endif

/* File: include/aacr_pkg.sv */
/*
 * Holds the types of the analog auxiliary control registers: the bus
 * request carrier, the unlock states and the state records.
 * Assumes the defines header is on the include path.
 */
`include "aacr_defines.svh"

package aacr_pkg;

   // One-hot states of the buffer configuration unlock sequence.
   typedef enum logic [2:0] {
      AACR_LOCK_IDLE = 3'h1,
      AACR_LOCK_OPEN = 3'h2,
      AACR_LOCK_STAGED = 3'h4
   } aacr_lock_state_type;

   // One bus request: strobes are single-cycle and never both high.
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } aacr_bus_req_type;

   // State of the unlock sequencer.
   typedef struct packed {
      aacr_lock_state_type lock;
      logic [`AACR_OPAMP_CHANNELS-1:0] staged;
      logic [`AACR_OPAMP_CHANNELS-1:0] cfg;
   } aacr_lock_reg_type;

   // State of one edge-set sticky flag.
   typedef struct packed {
      logic prev;
      logic flag;
   } aacr_flag_reg_type;

   // State of the register bank itself.
   typedef struct packed {
      logic sup_en;
      logic trip;
      logic cmp_en;
      logic [1:0] neg_sel;
      logic [1:0] route;
      logic [`AACR_EVENT_COUNT-1:0] evt_status;
      logic [`AACR_EVENT_COUNT-1:0] evt_mask;
      logic pin;
      logic [31:0] rdata;
   } aacr_main_reg_type;

endpackage

/* File: rtl/aacr_key_lock.sv */
/*
 * Holds the unlock sequencer that guards the op amp buffer configuration.
 * Assumes decoded single-cycle write strobes from the register bank.
 */
`timescale 1ns/100ps
`default_nettype none

module aacr_key_lock (
   input wire logic clk_in, // Core clock.
   input wire logic reset_n_in, // Asynchronous reset, active low.
   input wire logic key_first_wr_in, // Write to the first key register.
   input wire logic cfg_wr_in, // Write to the configuration register.
   input wire logic key_second_wr_in, // Write to the second key register.
   input wire logic other_wr_in, // Write to any other address.
   input wire logic [15:0] wdata_in, // Write data, low half.
   output logic [`AACR_OPAMP_CHANNELS-1:0] cfg_out // Committed configuration.
);

   aacr_pkg::aacr_lock_reg_type r;
   aacr_pkg::aacr_lock_reg_type next_r;

   // Any write that breaks the key, value, key order drops the sequence, except a
   // repeated right first key while open, so a stray store can never land in the configuration.
   always_comb begin
      next_r = r;
      case (r.lock)
         aacr_pkg::AACR_LOCK_IDLE: begin
            if (key_first_wr_in && wdata_in == `AACR_KEY_FIRST) begin
               next_r.lock = aacr_pkg::AACR_LOCK_OPEN;
            end
         end
         aacr_pkg::AACR_LOCK_OPEN: begin
            if (cfg_wr_in) begin
               next_r.staged = wdata_in[`AACR_OPAMP_CHANNELS-1:0];
               next_r.lock = aacr_pkg::AACR_LOCK_STAGED;
            end else if (key_second_wr_in || other_wr_in ||
                         (key_first_wr_in && wdata_in != `AACR_KEY_FIRST)) begin
               next_r.lock = aacr_pkg::AACR_LOCK_IDLE;
            end
         end
         aacr_pkg::AACR_LOCK_STAGED: begin
            if (key_second_wr_in && wdata_in == `AACR_KEY_SECOND) begin
               next_r.cfg = r.staged;
               next_r.lock = aacr_pkg::AACR_LOCK_IDLE;
            end else if (key_first_wr_in || cfg_wr_in || key_second_wr_in ||
                         other_wr_in) begin
               next_r.lock = aacr_pkg::AACR_LOCK_IDLE;
            end
         end
         default: begin
            next_r.lock = aacr_pkg::AACR_LOCK_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r.lock <= aacr_pkg::AACR_LOCK_IDLE;
         r.staged <= `AACR_OPAMP_CHANNELS'(`AACR_RESET_ZERO);
         r.cfg <= `AACR_OPAMP_CHANNELS'(`AACR_RESET_ZERO);
      end else begin
         r <= next_r;
      end
   end

   assign cfg_out = r.cfg;

endmodule

`default_nettype wire

/* File: rtl/aacr_edge_flag.sv */
/*
 * Holds one sticky flag set by an edge of a level and cleared by a
 * write of one, the clear being accepted only while it is allowed.
 * Assumes the level is synchronous to the core clock.
 */
`timescale 1ns/100ps
`default_nettype none

module aacr_edge_flag #(
   parameter logic RISE = 1'b1, // High to catch rising edges.
   parameter logic PREV_INIT = 1'b0 // Level assumed before reset release.
) (
   input wire logic clk_in, // Core clock.
   input wire logic reset_n_in, // Asynchronous reset, active low.
   input wire logic level_in, // Watched level.
   input wire logic clear_in, // One-cycle write-one-to-clear pulse.
   input wire logic clear_allow_in, // Clear accepted while high.
   output logic flag_out, // Sticky flag.
   output logic event_out // One-cycle edge pulse.
);

   aacr_pkg::aacr_flag_reg_type r;
   aacr_pkg::aacr_flag_reg_type next_r;
   logic edge_seen;

   // The edge sets the flag even in the cycle of a clear, so no edge is lost.
   always_comb begin
      next_r = r;
      edge_seen = RISE ? (level_in && !r.prev) : (!level_in && r.prev);
      next_r.prev = level_in;
      next_r.flag = edge_seen || (r.flag && !(clear_in && clear_allow_in));
   end

   // State register.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r.prev <= PREV_INIT;
         r.flag <= `AACR_RESET_BIT;
      end else begin
         r <= next_r;
      end
   end

   assign flag_out = r.flag;
   assign event_out = edge_seen;

endmodule

`default_nettype wire

/* File: rtl/aacr_regs.sv */
/*
 * Holds the register bank of the analog auxiliary functions: op amp
 * buffer configuration behind a key sequence, supply monitor control
 * with its low-supply flag, comparator control with its edge flags,
 * and an event status and mask pair feeding one interrupt line.
 * Assumes a plain register port with single-cycle strobes, inputs
 * synchronous to the core clock, and the interrupt controller's enable
 * bits for the supply monitor arriving as plain inputs.
 */
// Design decision made here: the plain strobed port.
// Notes on behaviour
// - Config bits 3..0 set op amp mode.
// - Key 0x9A, value, then key 0x0C.
// - Live supply bit; reads one when disabled.
// - Trip point select bit; one is reserved.
// - Supply monitor enable bit.
// - Low supply flag set on live fall.
// - Write one clears once supply high.
// - Supply request needs normal or fast enable.
// - Comparator enable bit.
// - Negative input select field, four codes.
// - Output route field; codes 00,01 reserved.
// - Sixteen-bit comparator register, upper reserved.
// - Positive input shared, output routable.
// - Route 10 to pin, 11 to interrupt.
// - Rising edge flag, write one clears.
`timescale 1ns/100ps
`default_nettype none

module aacr_regs (
   input wire logic clk_in, // Core clock, 250 MHz.
   input wire logic reset_n_in, // Asynchronous reset, active low.
   input wire aacr_pkg::aacr_bus_req_type bus_in, // Register bus request.
   output logic [31:0] rdata_out, // Read data, cycle after read strobe.
   input wire logic supply_comparator_in, // Supply above trip point.
   input wire logic comparator_result_in, // Voltage comparator result.
   input wire logic normal_irq_enable_in, // Supply source normal enable.
   input wire logic fast_irq_enable_in, // Supply source fast enable.
   output logic [`AACR_OPAMP_CHANNELS-1:0] opamp_mode_out, // Op amp mode.
   output logic supply_monitor_enable_out, // Supply monitor powered.
   output logic trip_point_select_out, // Trip point select.
   output logic comparator_enable_out, // Comparator powered.
   output logic [1:0] negative_input_select_out, // Negative input mux.
   output logic [1:0] output_route_select_out, // Output route mux.
   output logic comparator_output_pin_out, // Comparator output pin.
   output logic supply_irq_req_out, // Supply monitor request.
   output logic comparator_irq_req_out, // Comparator request.
   output logic event_irq_out // Masked event interrupt.
);

   // ------------
   // Address decode
   // ------------

   aacr_pkg::aacr_main_reg_type r;
   aacr_pkg::aacr_main_reg_type next_r;
   logic hit_sup;
   logic hit_cmp;
   logic hit_status;
   logic hit_mask;
   logic hit_key_first;
   logic hit_cfg;
   logic hit_key_second;
   logic wr_other;
   logic supply_above;
   logic sup_flag;
   logic rise_flag;
   logic fall_flag;
   logic sup_event;
   logic rise_event;
   logic fall_event;
   logic [`AACR_EVENT_COUNT-1:0] evt_pulse;
   logic [`AACR_EVENT_COUNT-1:0] evt_keep;

   // Full-address compare; anything else is unmapped and reads zero.
   assign hit_sup = bus_in.addr == `AACR_ADDR_SUPPLY_MONITOR_CONTROL;
   assign hit_cmp = bus_in.addr == `AACR_ADDR_COMPARATOR_CONTROL;
   assign hit_status = bus_in.addr == `AACR_ADDR_EVENT_STATUS;
   assign hit_mask = bus_in.addr == `AACR_ADDR_EVENT_MASK;
   assign hit_key_first = bus_in.addr == `AACR_ADDR_BUFFER_CONFIG_KEY_FIRST;
   assign hit_cfg = bus_in.addr == `AACR_ADDR_OPAMP_BUFFER_CONFIG;
   assign hit_key_second = bus_in.addr == `AACR_ADDR_BUFFER_CONFIG_KEY_SECOND;

   // Writes to any address outside the key sequence break the sequence.
   assign wr_other = bus_in.wr && !(hit_key_first || hit_cfg || hit_key_second);

   // ------------
   // Op amp buffer configuration
   // ------------

   // The sequencer owns the configuration so no plain write can reach it.
   aacr_key_lock u_key_lock (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .key_first_wr_in(bus_in.wr && hit_key_first),
      .cfg_wr_in(bus_in.wr && hit_cfg),
      .key_second_wr_in(bus_in.wr && hit_key_second),
      .other_wr_in(wr_other),
      .wdata_in(bus_in.wdata[15:0]),
      .cfg_out(opamp_mode_out)
   );

   // ------------
   // Supply monitor flag
   // ------------

   // A powered-down monitor reports the supply as good.
   assign supply_above = !r.sup_en || supply_comparator_in;

   // The clear is refused while the supply is still low, so the handler
   // cannot drop the flag before the supply has recovered.
   aacr_edge_flag #(
      .RISE(1'b0),
      .PREV_INIT(`AACR_RESET_BIT_HIGH)
   ) u_supply_flag (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .level_in(supply_above),
      .clear_in(bus_in.wr && hit_sup && bus_in.wdata[`AACR_SUP_FLAG_BIT]),
      .clear_allow_in(supply_above),
      .flag_out(sup_flag),
      .event_out(sup_event)
   );

   // ------------
   // Comparator edge flags
   // ------------

   // Rising edge flag, cleared by a write of one at any time.
   aacr_edge_flag #(
      .RISE(1'b1),
      .PREV_INIT(`AACR_RESET_BIT)
   ) u_rise_flag (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .level_in(comparator_result_in && r.cmp_en),
      .clear_in(bus_in.wr && hit_cmp && bus_in.wdata[`AACR_CMP_RISE_BIT]),
      .clear_allow_in(`AACR_RESET_BIT_HIGH),
      .flag_out(rise_flag),
      .event_out(rise_event)
   );

   // Falling edge flag, cleared the same way.
   aacr_edge_flag #(
      .RISE(1'b0),
      .PREV_INIT(`AACR_RESET_BIT)
   ) u_fall_flag (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .level_in(comparator_result_in && r.cmp_en),
      .clear_in(bus_in.wr && hit_cmp && bus_in.wdata[`AACR_CMP_FALL_BIT]),
      .clear_allow_in(`AACR_RESET_BIT_HIGH),
      .flag_out(fall_flag),
      .event_out(fall_event)
   );

   // ------------
   // Event status bits
   // ------------

   assign evt_pulse = {fall_event, rise_event, sup_event};

   // A read clears the status, but an event in the same cycle survives.
   generate
      for (genvar i = 0; i < `AACR_EVENT_COUNT; i++) begin : g_evt
         assign evt_keep[i] = evt_pulse[i] ||
                              (r.evt_status[i] && !(bus_in.rd && hit_status));
      end
   endgenerate

   // ------------
   // Register update and read data
   // ------------

   // Stored fields, routed outputs and the registered read answer.
   always_comb begin
      next_r = r;
      next_r.evt_status = evt_keep;
      if (bus_in.wr && hit_sup) begin
         next_r.trip = bus_in.wdata[`AACR_SUP_TRIP_BIT];
         next_r.sup_en = bus_in.wdata[`AACR_SUP_ENABLE_BIT];
      end
      if (bus_in.wr && hit_cmp) begin
         next_r.cmp_en = bus_in.wdata[`AACR_CMP_ENABLE_BIT];
         next_r.neg_sel = bus_in.wdata[`AACR_CMP_NEG_HI:`AACR_CMP_NEG_LO];
         next_r.route = bus_in.wdata[`AACR_CMP_ROUTE_HI:`AACR_CMP_ROUTE_LO];
      end
      if (bus_in.wr && hit_mask) begin
         next_r.evt_mask = bus_in.wdata[`AACR_EVENT_COUNT-1:0];
      end
      // The pin follows the comparator only when routed out and powered.
      next_r.pin = r.cmp_en && (r.route == `AACR_ROUTE_PIN) &&
                   comparator_result_in;
      next_r.rdata = `AACR_RESET_ZERO;
      if (bus_in.rd) begin
         if (hit_sup) begin
            next_r.rdata[`AACR_SUP_ABOVE_BIT] = supply_above;
            next_r.rdata[`AACR_SUP_TRIP_BIT] = r.trip;
            next_r.rdata[`AACR_SUP_ENABLE_BIT] = r.sup_en;
            next_r.rdata[`AACR_SUP_FLAG_BIT] = sup_flag;
         end else if (hit_cmp) begin
            // Upper bits stay zero: the register is sixteen bits wide.
            next_r.rdata[`AACR_CMP_ENABLE_BIT] = r.cmp_en;
            next_r.rdata[`AACR_CMP_NEG_HI:`AACR_CMP_NEG_LO] = r.neg_sel;
            next_r.rdata[`AACR_CMP_ROUTE_HI:`AACR_CMP_ROUTE_LO] = r.route;
            next_r.rdata[`AACR_CMP_RISE_BIT] = rise_flag;
            next_r.rdata[`AACR_CMP_FALL_BIT] = fall_flag;
         end else if (hit_cfg) begin
            next_r.rdata[`AACR_OPAMP_CHANNELS-1:0] = opamp_mode_out;
         end else if (hit_status) begin
            next_r.rdata[`AACR_EVENT_COUNT-1:0] = r.evt_status;
         end else if (hit_mask) begin
            next_r.rdata[`AACR_EVENT_COUNT-1:0] = r.evt_mask;
         end
      end
   end

   // State register.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r.sup_en <= `AACR_RESET_BIT;
         r.trip <= `AACR_RESET_BIT;
         r.cmp_en <= `AACR_RESET_BIT;
         r.neg_sel <= 2'(`AACR_RESET_ZERO);
         r.route <= 2'(`AACR_RESET_ZERO);
         r.evt_status <= `AACR_EVENT_COUNT'(`AACR_RESET_ZERO);
         r.evt_mask <= `AACR_EVENT_COUNT'(`AACR_RESET_ZERO);
         r.pin <= `AACR_RESET_BIT;
         r.rdata <= `AACR_RESET_ZERO;
      end else begin
         r <= next_r;
      end
   end

   // ------------
   // Outputs
   // ------------

   assign rdata_out = r.rdata;
   assign supply_monitor_enable_out = r.sup_en;
   assign trip_point_select_out = r.trip;
   assign comparator_enable_out = r.cmp_en;
   assign negative_input_select_out = r.neg_sel;
   assign output_route_select_out = r.route;
   assign comparator_output_pin_out = r.pin;

   // The flag only reaches the core when one enable is set.
   assign supply_irq_req_out = sup_flag &&
                               (normal_irq_enable_in || fast_irq_enable_in);

   // Route 11 turns the rising edge flag into a request.
   assign comparator_irq_req_out = r.cmp_en && (r.route == `AACR_ROUTE_IRQ) &&
                                   rise_flag;

   // Level interrupt while any unmasked status bit is set.
   assign event_irq_out = |(r.evt_status & r.evt_mask);

endmodule

`default_nettype wire

/* File: testbench/aacr_regs_monitor.sv */
/*
 * Holds the concurrent checks of the analog auxiliary register bank.
 * Assumes it is bound to aacr_regs and sees only that module's ports.
 */
`timescale 1ns/100ps
`default_nettype none
`include "aacr_defines.svh"

module aacr_regs_monitor (
   input wire logic clk_in, // Core clock.
   input wire logic reset_n_in, // Reset, active low.
   input wire aacr_pkg::aacr_bus_req_type bus_in, // Bus request.
   input wire logic [31:0] rdata_out, // Read data.
   input wire logic supply_comparator_in, // Supply level.
   input wire logic comparator_result_in, // Comparator level.
   input wire logic normal_irq_enable_in, // Normal enable.
   input wire logic fast_irq_enable_in, // Fast enable.
   input wire logic [`AACR_OPAMP_CHANNELS-1:0] opamp_mode_out, // Op amp mode.
   input wire logic supply_monitor_enable_out, // Monitor on.
   input wire logic trip_point_select_out, // Trip select.
   input wire logic comparator_enable_out, // Comparator on.
   input wire logic [1:0] negative_input_select_out, // Negative mux.
   input wire logic [1:0] output_route_select_out, // Route mux.
   input wire logic comparator_output_pin_out, // Output pin.
   input wire logic supply_irq_req_out, // Supply request.
   input wire logic comparator_irq_req_out, // Comparator request.
   input wire logic event_irq_out // Event interrupt.
);
   // ------------------------------
   // Decoded bus cycles
   // ------------------------------
   // Decoding once keeps each property short and about one thing.
   wire logic wr_sup = bus_in.wr && bus_in.addr == `AACR_ADDR_SUPPLY_MONITOR_CONTROL;
   wire logic rd_sup = bus_in.rd && bus_in.addr == `AACR_ADDR_SUPPLY_MONITOR_CONTROL;
   wire logic rd_cmp = bus_in.rd && bus_in.addr == `AACR_ADDR_COMPARATOR_CONTROL;
   wire logic wr_k1 = bus_in.wr && bus_in.addr == `AACR_ADDR_BUFFER_CONFIG_KEY_FIRST
      && bus_in.wdata[15:0] == `AACR_KEY_FIRST;
   wire logic wr_cfg = bus_in.wr && bus_in.addr == `AACR_ADDR_OPAMP_BUFFER_CONFIG;
   wire logic wr_k2 = bus_in.wr && bus_in.addr == `AACR_ADDR_BUFFER_CONFIG_KEY_SECOND
      && bus_in.wdata[15:0] == `AACR_KEY_SECOND;
   wire logic live = !supply_monitor_enable_out || supply_comparator_in;
   wire logic any_en = normal_irq_enable_in || fast_irq_enable_in;

   // ------------------------------
   // Properties
   // ------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_unlock;
      wr_k1 ##1 wr_cfg ##1 wr_k2;
   endsequence
   property p_unlock;
      s_unlock |=> opamp_mode_out == $past(bus_in.wdata[3:0], 2);
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock did not commit");
   property p_change;
      !$stable(opamp_mode_out) |-> $past(wr_k2);
   endproperty
   a_change: assert property (p_change) else $error("config changed unkeyed");
   property p_live;
      rd_sup |=> rdata_out[3] == $past(live);
   endproperty
   a_live: assert property (p_live) else $error("live bit wrong");
   property p_en_wr;
      wr_sup |=> supply_monitor_enable_out == $past(bus_in.wdata[1])
         && trip_point_select_out == $past(bus_in.wdata[2]);
   endproperty
   a_en_wr: assert property (p_en_wr) else $error("monitor bits wrong");
   property p_low_set;
      $fell(live) ##1 any_en |-> supply_irq_req_out;
   endproperty
   a_low_set: assert property (p_low_set) else $error("low flag not set");
   property p_clr_refused;
      supply_irq_req_out && !live && wr_sup && bus_in.wdata[0] ##1 any_en
         |-> supply_irq_req_out;
   endproperty
   a_clr_refused: assert property (p_clr_refused) else $error("flag cleared low");
   property p_cmp_rsvd;
      rd_cmp |=> rdata_out[15:11] == 5'h00;
   endproperty
   a_cmp_rsvd: assert property (p_cmp_rsvd) else $error("reserved bits set");
   property p_pin;
      comparator_enable_out && output_route_select_out == `AACR_ROUTE_PIN
         |=> comparator_output_pin_out == $past(comparator_result_in);
   endproperty
   a_pin: assert property (p_pin) else $error("pin not following");
   property p_cmp_irq;
      comparator_enable_out && output_route_select_out == `AACR_ROUTE_IRQ
         && $rose(comparator_result_in) |=> comparator_irq_req_out
         || !comparator_enable_out || output_route_select_out != `AACR_ROUTE_IRQ;
   endproperty
   a_cmp_irq: assert property (p_cmp_irq) else $error("irq route wrong");
endmodule

bind aacr_regs aacr_regs_monitor u_monitor (.clk_in, .reset_n_in, .bus_in, .rdata_out,
   .supply_comparator_in, .comparator_result_in, .normal_irq_enable_in,
   .fast_irq_enable_in, .opamp_mode_out, .supply_monitor_enable_out,
   .trip_point_select_out, .comparator_enable_out, .negative_input_select_out,
   .output_route_select_out, .comparator_output_pin_out, .supply_irq_req_out,
   .comparator_irq_req_out, .event_irq_out);
`default_nettype wire

/* File: testbench/testbench.sv */
/*
 * Holds the self-checking bench of the analog auxiliary register bank.
 * Assumes the package, the defines header and the checker come first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "aacr_defines.svh"

module testbench;
   // ------------------------------
   // Signals and cases
   // ------------------------------
   typedef struct packed {
      logic [31:0] addr, data, exp;
   } aacr_tb_row_type;
   localparam logic [31:0] ad_sup = `AACR_ADDR_SUPPLY_MONITOR_CONTROL;
   localparam logic [31:0] ad_cmp = `AACR_ADDR_COMPARATOR_CONTROL;
   localparam logic [31:0] ad_cfg = `AACR_ADDR_OPAMP_BUFFER_CONFIG;
   logic clk_in, reset_n_in, supply_comparator_in, comparator_result_in;
   logic normal_irq_enable_in, fast_irq_enable_in, supply_monitor_enable_out;
   logic trip_point_select_out, comparator_enable_out, comparator_output_pin_out;
   logic supply_irq_req_out, comparator_irq_req_out, event_irq_out;
   logic [1:0] negative_input_select_out, output_route_select_out;
   logic [3:0] opamp_mode_out;
   logic [31:0] rdata_out;
   aacr_pkg::aacr_bus_req_type bus_in;
   int miscompares = 0;
   int cmp_count = 0;
   // Write then read back; unmapped and key places read zero.
   aacr_tb_row_type rows [7] = '{
      '{ad_cmp, 32'h7ff, 32'h7c0}, '{ad_cmp, 32'h680, 32'h680}, '{ad_sup, 32'h6, 32'he},
      '{ad_sup, 32'h0, 32'h8}, '{ad_cfg, 32'h5, 32'h0},
      '{`AACR_ADDR_BUFFER_CONFIG_KEY_FIRST, 32'h9a, 32'h0},
      '{32'hffff_0448, 32'hffff_ffff, 32'h0}};

   aacr_regs dut (.clk_in, .reset_n_in, .bus_in, .rdata_out, .supply_comparator_in,
      .comparator_result_in, .normal_irq_enable_in, .fast_irq_enable_in, .opamp_mode_out,
      .supply_monitor_enable_out, .trip_point_select_out, .comparator_enable_out,
      .negative_input_select_out, .output_route_select_out, .comparator_output_pin_out,
      .supply_irq_req_out, .comparator_irq_req_out, .event_irq_out);

   // The 250 MHz core clock.
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // ------------------------------
   // Bus and check tasks
   // ------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Puts give back-to-back one-cycle writes; the caller idles the bus after.
   task automatic put(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus_in <= '{a, d, 1'b1, 1'b0};
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      put(a, d);
      idle();
   endtask
   task automatic idle();
      @(posedge clk_in);
      bus_in <= '0;
      @(negedge clk_in);
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input string name, input logic [31:0] a, input logic [31:0] e);
      @(posedge clk_in);
      bus_in <= '{a, 32'h0, 1'b0, 1'b1};
      idle();
      chk(name, e, rdata_out);
   endtask
   task automatic seq(input logic [31:0] k1, input logic [31:0] v, input logic [31:0] mid,
                      input logic [31:0] k2);
      put(`AACR_ADDR_BUFFER_CONFIG_KEY_FIRST, k1);
      put(ad_cfg, v);
      if (mid != 32'h0) put(mid, 32'h0);
      put(`AACR_ADDR_BUFFER_CONFIG_KEY_SECOND, k2);
      idle();
   endtask
   task automatic done(input string name);
      $display("Test %s finished", name);
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // The whole run needs about a hundred cycles; this leaves wide margin.
   initial begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      end_sim();
   end

   // ------------------------------
   // Tests
   // ------------------------------
   initial begin
      reset_n_in = 1'b0;
      bus_in = '0;
      supply_comparator_in = 1'b1;
      comparator_result_in = 1'b0;
      normal_irq_enable_in = 1'b0;
      fast_irq_enable_in = 1'b0;
      repeat (10) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rd("sup reset", ad_sup, 32'h8);
      rd("cmp reset", ad_cmp, 32'h0);
      chk("opamp reset", 32'h0, opamp_mode_out);
      done("reset");
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].data);
         rd("row readback", rows[i].addr, rows[i].exp);
      end
      for (int c = 0; c < 4; c++) begin
         wr(ad_cmp, 32'(c) * 32'h140);
         chk("neg sel", 32'(c), negative_input_select_out);
         chk("route", 32'(c), output_route_select_out);
      end
      done("table");
      seq(32'h9a, 32'h5, 32'h0, 32'hc);
      chk("unlock", 32'h5, opamp_mode_out);
      seq(32'h9b, 32'ha, 32'h0, 32'hc);
      chk("bad first key", 32'h5, opamp_mode_out);
      seq(32'h9a, 32'ha, ad_sup, 32'hc);
      chk("broken order", 32'h5, opamp_mode_out);
      seq(32'h9a, 32'ha, 32'h0, 32'hd);
      chk("bad second key", 32'h5, opamp_mode_out);
      seq(32'h9a, 32'ha, 32'h0, 32'hc);
      rd("cfg readback", ad_cfg, 32'ha);
      done("keys");
      wr(`AACR_ADDR_EVENT_MASK, 32'h1);
      wr(ad_sup, 32'h2);
      @(posedge clk_in) normal_irq_enable_in <= 1'b1;
      @(posedge clk_in) supply_comparator_in <= 1'b0;
      idle();
      chk("low flag", 32'h1, supply_irq_req_out);
      chk("event irq", 32'h1, event_irq_out);
      wr(ad_sup, 32'h3);
      chk("clear while low", 32'h1, supply_irq_req_out);
      @(posedge clk_in) supply_comparator_in <= 1'b1;
      rd("live back high", ad_sup, 32'hb);
      wr(ad_sup, 32'h2);
      @(posedge clk_in) normal_irq_enable_in <= 1'b0;
      @(posedge clk_in) fast_irq_enable_in <= 1'b1;
      idle();
      chk("zero write", 32'h1, supply_irq_req_out);
      @(posedge clk_in) fast_irq_enable_in <= 1'b0;
      idle();
      chk("no enable", 32'h0, supply_irq_req_out);
      rd("status", `AACR_ADDR_EVENT_STATUS, 32'h1);
      chk("status cleared", 32'h0, event_irq_out);
      wr(ad_sup, 32'h3);
      rd("flag cleared", ad_sup, 32'ha);
      done("supply");
      wr(ad_cmp, 32'h4c0);
      @(posedge clk_in) comparator_result_in <= 1'b1;
      idle();
      chk("cmp irq", 32'h1, comparator_irq_req_out);
      chk("masked", 32'h0, event_irq_out);
      wr(ad_cmp, 32'h4c2);
      chk("rise cleared", 32'h0, comparator_irq_req_out);
      wr(ad_cmp, 32'h480);
      idle();
      chk("pin", 32'h1, comparator_output_pin_out);
      done("comparator");
      end_sim();
   end
endmodule
`default_nettype wire
